// ===== sim/jsl_link_init_props.sv
// checker for the link sync block
`timescale 1ns/100ps
`default_nettype none
module jsl_link_init_props
    import jsl_pkg::*;
#(parameter int ILAS_MFRAMES = 4) (
    // clock, reset, pins, configuration
    input wire logic clk,
    input wire logic arst_n,
    input wire logic single_ended_sync_pin,
    input wire logic timestamp_diff_pair,
    input wire logic sysref_pin,
    input wire logic sync_sel,
    input wire logic timestamp_receiver_enable,
    input wire logic mode_64b66b,
    input wire logic nco_sync_en,
    // status
    input wire logic send_cgs,
    input wire logic send_ilas,
    input wire logic send_data,
    input wire logic mf_start,
    input wire logic nco_sync,
    input wire logic tstamp_mark,
    input wire jsl_pkg::jsl_state_t link_state
);
    wire sync_n = sync_sel ? (timestamp_receiver_enable ? timestamp_diff_pair : 1'b1)
                           : single_ended_sync_pin;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_cgs_on_low: assert property ((!mode_64b66b && !sync_n)[*4] |-> send_cgs)
        else $error("no cgs on low sync");
    a_ilas_after_cgs: assert property ($fell(send_cgs) && !mode_64b66b |-> send_ilas)
        else $error("no ilas after cgs");
    a_ilas_bounded: assert property ($rose(send_ilas) |-> ##[1:80] !send_ilas)
        else $error("ilas too long");
    a_no_init_64: assert property (mode_64b66b[*4] |-> send_data && !send_cgs)
        else $error("init in 64b66b");
    a_nco_pulse: assert property (nco_sync |-> mode_64b66b && nco_sync_en ##1 !nco_sync)
        else $error("bad nco pulse");
    a_sysref_align: assert property ($rose(sysref_pin) |-> ##3 mf_start)
        else $error("no realign");
    a_tstamp_on: assert property ((timestamp_receiver_enable && !timestamp_diff_pair)
        [*4] |-> tstamp_mark)
        else $error("no timestamp");
    a_tstamp_off: assert property ((!timestamp_receiver_enable)[*4] |-> !tstamp_mark)
        else $error("pair not ignored");
    a_cgs_held: assert property ((!mode_64b66b && !sync_n)[*3] ##0 send_cgs
        |=> send_cgs)
        else $error("cgs dropped while sync low");
endmodule
bind jsl_link_init jsl_link_init_props #(.ILAS_MFRAMES(ILAS_MFRAMES)) u_props (.*);
`default_nettype wire

// ===== sim/jsl_link_init_tb.sv
// self-checking bench for the link sync block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("mismatch %s expected %0h seen %0h", nm, e, a); end end
module jsl_link_init_tb;
    import jsl_pkg::*;
    logic clk = 0, arst_n = 0, pin = 1, pair = 1, sref = 0, sel = 0, en = 0;
    logic m64 = 0, nen = 0, req = 0, rx_n, cgs, ilas, data, mfs, nco, ts;
    logic [7:0] hold = 8'h01;
    jsl_state_t st;
    int error_cnt = 0, total_checks = 0, i;
    wire se_w = sel ? 1'b0 : (rx_n & pin);
    wire df_w = sel ? (rx_n & pair) : pair;
    always #10 clk = ~clk;
    jsl_rx_model u_jsl_rx_model (.clk(clk), .arst_n(arst_n), .req(req), .hold(hold),
        .send_cgs(cgs), .sync_n(rx_n));
    jsl_link_init #(.ILAS_MFRAMES(4)) u_jsl_link_init (.clk(clk), .arst_n(arst_n),
        .single_ended_sync_pin(se_w), .timestamp_diff_pair(df_w), .sysref_pin(sref),
        .sync_sel(sel), .timestamp_receiver_enable(en), .mode_64b66b(m64),
        .nco_sync_en(nen), .send_cgs(cgs), .send_ilas(ilas), .send_data(data),
        .mf_start(mfs), .nco_sync(nco), .tstamp_mark(ts), .link_state(st));
    task automatic wait_data();
        for (i = 0; i < 120 && data !== 1'b1; i++) @(negedge clk);
    endtask
    task automatic t_link(input logic s, input logic [7:0] h);
        sel = s;
        en = s;
        hold <= h;
        req <= 1'b1;
        for (i = 0; i < 20 && cgs !== 1'b1; i++) @(negedge clk);
        `CHK("cgs", JSL_ST_CGS, st)
        for (i = 0; i < 80 && ilas !== 1'b1; i++) @(negedge clk);
        `CHK("ilas", 1'b1, ilas)
        wait_data();
        `CHK("data", 1'b1, data)
        req <= 1'b0;
        @(negedge clk);
        $display("link test done");
    endtask
    task automatic t_en();
        en = 0;
        pair = 0;
        repeat (10) @(negedge clk);
        `CHK("ignored", 1'b0, cgs | ts)
        en = 1;
        repeat (6) @(negedge clk);
        `CHK("pair cgs", 1'b1, cgs)
        `CHK("stamp", 1'b1, ts)
        pair = 1;
        wait_data();
        `CHK("pair data", 1'b1, data)
        en = 0;
        sel = 0;
        repeat (4) @(negedge clk);
        wait_data();
        `CHK("pin data", 1'b1, data)
        $display("enable test done");
    endtask
    task automatic t_64();
        m64 = 1;
        nen = 1;
        pin = 0;
        for (i = 0; i < 10 && nco !== 1'b1; i++) @(negedge clk);
        `CHK("nco", 1'b1, nco)
        repeat (5) @(negedge clk);
        `CHK("no cgs", 1'b0, cgs)
        pin = 1;
        repeat (5) @(negedge clk);
        m64 = 0;
        $display("64b66b test done");
    endtask
    task automatic t_sref();
        sref = 1;
        repeat (3) @(negedge clk);
        `CHK("realign", 1'b1, mfs)
        repeat (15) @(negedge clk);
        `CHK("mf gap", 1'b0, mfs)
        @(negedge clk);
        `CHK("mf next", 1'b1, mfs)
        sref = 0;
        $display("sysref test done");
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clk);
        arst_n <= 1'b1;
        t_link(1'b0, 8'h01);
        t_link(1'b1, 8'h28);
        t_en();
        t_64();
        t_sref();
        give_verdict();
    end
    initial begin
        #100us;
        error_cnt++;
        give_verdict();
    end
endmodule
`default_nettype wire

// ===== sim/jsl_rx_model.sv
// far-side receiver model driving the active-low link request
`timescale 1ns/100ps
`default_nettype none
module jsl_rx_model (
    // clock, reset, control
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       req,
    input  wire logic [7:0] hold,
    input  wire logic       send_cgs,
    // request, active low
    output var  logic       sync_n
);
    logic [7:0] cnt;
    always @(negedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 8'h00;
            sync_n <= 1'b1;
        end else begin
            cnt <= !req ? 8'h00 : (send_cgs && cnt < hold) ? cnt + 8'h01 : cnt;
            sync_n <= !(req && cnt < hold);
        end
    end
endmodule
`default_nettype wire

// ===== src/jsl_link_init.sv
// link initialisation sync handling: cgs, ilas, sysref alignment, nco trigger
//
// Notes on behaviour
// - With select 0 in 8b/10b mode the single-ended pin is an active-low link request.
// - In 64b/66b mode sync never starts link init but can trigger nco sync.
// - A low sync in 8b/10b mode starts code group synchronisation.
// - Sync returning high after code group sync starts the lane alignment sequence.
// - With select 1 sync comes from the differential timestamp pair.
// - Sysref aligns the internal framing counter for deterministic latency.
// - The differential pair is active low when used as sync.
// - The differential pair is ignored unless its receiver enable is 1.
// - The differential pair can act as timestamp and sync at once.
`timescale 1ns/100ps
`default_nettype none
`include "jsl_regs.svh"
module jsl_link_init
    import jsl_pkg::*;
#(
    parameter int ILAS_MFRAMES = `JSL_ILAS_MFRAMES
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // pins
    input  wire logic single_ended_sync_pin,
    input  wire logic timestamp_diff_pair,
    input  wire logic sysref_pin,
    // configuration
    input  wire logic sync_sel,
    input  wire logic timestamp_receiver_enable,
    input  wire logic mode_64b66b,
    input  wire logic nco_sync_en,
    // status and lane control
    output var  logic send_cgs,
    output var  logic send_ilas,
    output var  logic send_data,
    output var  logic mf_start,
    output var  logic nco_sync,
    output var  logic tstamp_mark,
    output var  jsl_pkg::jsl_state_t link_state
);
    import jsl_pkg::*;

    jsl_sync_if sif ();

    jsl_sync_front u_front (
        .clk                       (clk),
        .arst_n                    (arst_n),
        .single_ended_sync_pin     (single_ended_sync_pin),
        .timestamp_diff_pair       (timestamp_diff_pair),
        .sysref_pin                (sysref_pin),
        .sync_sel                  (sync_sel),
        .timestamp_receiver_enable (timestamp_receiver_enable),
        .sif                       (sif)
    );

    // ****************************************
    // helpers
    // ****************************************
    // one-hot state test for the lane selects
    function automatic logic jsl_in_state(
        input jsl_state_t cur,
        input jsl_state_t want
    );
        return (cur == want);
    endfunction

    // level change towards lvl between two samples
    function automatic logic jsl_changed_to(
        input logic prev,
        input logic cur,
        input logic lvl
    );
        return (prev != lvl) && (cur == lvl);
    endfunction

    // ****************************************
    // framing counter and edges
    // ****************************************
    logic [`JSL_MF_CNT_W-1:0]   mf_cnt;
    logic [`JSL_MF_CNT_W-1:0]   next_mf_cnt;
    logic                       sysref_d;
    logic                       sync_d;
    logic                       sysref_rise;
    logic                       sync_fall;
    logic                       mf_edge;
    logic                       next_sysref_d;
    logic                       next_sync_d;

    assign sysref_rise = jsl_changed_to(sysref_d, sif.sysref, 1'b1);
    assign sync_fall   = jsl_changed_to(sync_d, sif.sync_n, 1'b0);

    always_comb begin
        if (sysref_rise) begin
            next_mf_cnt = '0;
        end else if (mf_cnt == `JSL_MF_CNT_W'(`JSL_MF_CYCLES - 1)) begin
            next_mf_cnt = '0;
        end else begin
            next_mf_cnt = mf_cnt + 1'b1;
        end
        mf_edge       = (next_mf_cnt == '0);
        next_sysref_d = sif.sysref;
        next_sync_d   = sif.sync_n;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mf_cnt   <= '0;
            sysref_d <= 1'b0;
            sync_d   <= 1'b1;
        end else begin
            mf_cnt   <= next_mf_cnt;
            sysref_d <= next_sysref_d;
            sync_d   <= next_sync_d;
        end
    end

    // ****************************************
    // link state machine
    // ****************************************
    jsl_state_t                 state;
    jsl_state_t                 next_state;
    logic [`JSL_ILAS_CNT_W-1:0] ilas_cnt;
    logic [`JSL_ILAS_CNT_W-1:0] next_ilas_cnt;

    always_comb begin
        next_state    = state;
        next_ilas_cnt = ilas_cnt;
        case (state)
            JSL_ST_IDLE: begin
                if (!mode_64b66b && !sif.sync_n) begin
                    next_state = JSL_ST_CGS;
                end
            end
            JSL_ST_CGS: begin
                if (sif.sync_n) begin
                    next_state    = JSL_ST_ILAS;
                    next_ilas_cnt = '0;
                end
            end
            JSL_ST_ILAS: begin
                if (!sif.sync_n) begin
                    next_state = JSL_ST_CGS;
                end else if (mf_edge) begin
                    if (ilas_cnt == `JSL_ILAS_CNT_W'(ILAS_MFRAMES - 1)) begin
                        next_state = JSL_ST_DATA;
                    end else begin
                        next_ilas_cnt = ilas_cnt + 1'b1;
                    end
                end
            end
            JSL_ST_DATA: begin
                if (!sif.sync_n) begin
                    next_state = JSL_ST_CGS;
                end
            end
            default: begin
                next_state = JSL_ST_IDLE;
            end
        endcase
        if (mode_64b66b) begin
            next_state = JSL_ST_DATA;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state    <= JSL_ST_IDLE;
            ilas_cnt <= '0;
        end else begin
            state    <= next_state;
            ilas_cnt <= next_ilas_cnt;
        end
    end

    // ****************************************
    // registered outputs
    // ****************************************
    logic                       next_send_cgs;
    logic                       next_send_ilas;
    logic                       next_send_data;
    logic                       next_mf_start;
    logic                       next_nco_sync;
    logic                       next_tstamp_mark;

    always_comb begin
        next_send_cgs    = jsl_in_state(next_state, JSL_ST_CGS);
        next_send_ilas   = jsl_in_state(next_state, JSL_ST_ILAS);
        next_send_data   = jsl_in_state(next_state, JSL_ST_DATA);
        next_mf_start    = mf_edge;
        next_nco_sync    = mode_64b66b & nco_sync_en & sync_fall;
        next_tstamp_mark = sif.tstamp;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            send_cgs    <= 1'b0;
            send_ilas   <= 1'b0;
            send_data   <= 1'b0;
            mf_start    <= 1'b0;
            nco_sync    <= 1'b0;
            tstamp_mark <= 1'b0;
            link_state  <= JSL_ST_IDLE;
        end else begin
            send_cgs    <= next_send_cgs;
            send_ilas   <= next_send_ilas;
            send_data   <= next_send_data;
            mf_start    <= next_mf_start;
            nco_sync    <= next_nco_sync;
            tstamp_mark <= next_tstamp_mark;
            link_state  <= next_state;
        end
    end
endmodule
`default_nettype wire

// ===== src/jsl_pkg.sv
// types for the link sync block
package jsl_pkg;
    typedef enum logic [3:0] {
        JSL_ST_IDLE = 4'b0001,
        JSL_ST_CGS  = 4'b0010,
        JSL_ST_ILAS = 4'b0100,
        JSL_ST_DATA = 4'b1000
    } jsl_state_t;
endpackage

// ===== src/jsl_regs.svh
// timing counts and field constants for the link sync block
`ifndef JSL_REGS_SVH
`define JSL_REGS_SVH
`define JSL_ILAS_MFRAMES      4
`define JSL_MF_CYCLES         16
`define JSL_MF_CNT_W          4
`define JSL_ILAS_CNT_W        3
`define JSL_SYNC_SEL_PIN      1'b0
`define JSL_SYNC_SEL_DIFF     1'b1
`endif

// ===== src/jsl_sync_front.sv
// sync source select and two-flop synchronisers for the link pins
`timescale 1ns/100ps
`default_nettype none
module jsl_sync_front (
    // clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // pins
    input  wire logic single_ended_sync_pin,
    input  wire logic timestamp_diff_pair,
    input  wire logic sysref_pin,
    // configuration
    input  wire logic sync_sel,
    input  wire logic timestamp_receiver_enable,
    // synchronised levels
    jsl_sync_if.front sif
);
    logic [1:0] se_ff;
    logic [1:0] df_ff;
    logic [1:0] sr_ff;
    logic [1:0] next_se_ff;
    logic [1:0] next_df_ff;
    logic [1:0] next_sr_ff;
    logic       diff_ok;

    always_comb begin
        next_se_ff = {se_ff[0], single_ended_sync_pin};
        next_df_ff = {df_ff[0], timestamp_diff_pair};
        next_sr_ff = {sr_ff[0], sysref_pin};
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            se_ff <= 2'b11;
            df_ff <= 2'b11;
            sr_ff <= 2'b00;
        end else begin
            se_ff <= next_se_ff;
            df_ff <= next_df_ff;
            sr_ff <= next_sr_ff;
        end
    end

    assign diff_ok = timestamp_receiver_enable;
    assign sif.sync_n = (sync_sel == `JSL_SYNC_SEL_DIFF) ? (diff_ok ? df_ff[1] : 1'b1)
                                                        : se_ff[1];
    assign sif.tstamp = diff_ok & ~df_ff[1];
    assign sif.sysref = sr_ff[1];
endmodule
`default_nettype wire

// ===== src/jsl_sync_if.sv
// synchronised pin levels passed from the front end to the link logic
`timescale 1ns/100ps
`default_nettype none
interface jsl_sync_if;
    logic sync_n;
    logic sysref;
    logic tstamp;
    modport front (output sync_n, output sysref, output tstamp);
    modport core  (input sync_n, input sysref, input tstamp);
endinterface
`default_nettype wire
